/* hw/line_event_status.sv */
// line interface event status, jitter measurement and interrupt logic
//
// Implementation choice: register access over AHB-Lite.
`default_nettype none
`include "line_event_defs.svh"
module line_event_status
    import line_event_pkg::*;
#(
    parameter int ADDR_W = 12,
    parameter int PTR_W  = 7
) (
    input  wire logic              hclk,
    input  wire logic              hresetn,
    input  wire logic              hsel,
    input  wire logic [ADDR_W-1:0] haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic                   hreadyout,
    output logic      [31:0]       hrdata,
    output logic                   hresp,
    input  wire logic              driver_fail_live,
    input  wire logic              signal_loss_live,
    input  wire logic              template_overflow,
    input  wire logic              tx_fifo_slip,
    input  wire logic              rx_fifo_slip,
    input  wire logic              excess_zeros,
    input  wire logic              bipolar_violation,
    input  wire logic [PTR_W-1:0]  tx_wr_ptr,
    input  wire logic [PTR_W-1:0]  tx_rd_ptr,
    input  wire logic [PTR_W-1:0]  rx_wr_ptr,
    input  wire logic [PTR_W-1:0]  rx_rd_ptr,
    input  wire logic              mclk_level,
    input  wire logic              recovered_clk_level,
    input  wire logic [7:0]        block_pending,
    output logic                   ref_clock_out_a,
    output logic                   ref_clock_out_b,
    output logic                   irq
);
    initial begin
        if (ADDR_W < 12) $error("line_event_status: ADDR_W must be at least 12");
        if (PTR_W < 2 || PTR_W > 7) $error("line_event_status: PTR_W must be 2 to 7");
    end

    // ----------------------------------------------------------------
    // bus address phase capture
    // ----------------------------------------------------------------
    logic     wr_q;
    reg_idx_t widx_q;
    logic     take;
    logic     take_wr;
    logic     take_rd;
    reg_idx_t aidx;

    assign take    = hsel & htrans[1] & hready;
    assign take_wr = take & hwrite;
    assign take_rd = take & ~hwrite;
    assign aidx    = haddr[11:2];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_q   <= 1'b0;
            widx_q <= 10'h000;
        end else begin
            wr_q   <= take_wr;
            widx_q <= aidx;
        end
    end

    // ----------------------------------------------------------------
    // write strobes, applied in the data phase
    // ----------------------------------------------------------------
    reg_byte_t wbyte;
    logic      we_en_a;
    logic      we_en_b;
    logic      we_edge;
    logic      we_tx_gap;
    logic      we_rx_gap;
    logic      we_stat_a;
    logic      we_stat_b;
    logic      we_ref;
    logic      we_ctrl;

    assign wbyte     = hwdata[7:0];
    assign we_en_a   = wr_q & (widx_q == `IDX_IRQ_ENABLE_A);
    assign we_en_b   = wr_q & (widx_q == `IDX_IRQ_ENABLE_B);
    assign we_edge   = wr_q & (widx_q == `IDX_EDGE_SELECT);
    assign we_tx_gap = wr_q & (widx_q == `IDX_TX_GAP);
    assign we_rx_gap = wr_q & (widx_q == `IDX_RX_GAP);
    assign we_stat_a = wr_q & (widx_q == `IDX_STATUS_A);
    assign we_stat_b = wr_q & (widx_q == `IDX_STATUS_B);
    assign we_ref    = wr_q & (widx_q == `IDX_REF_CONTROL);
    assign we_ctrl   = wr_q & (widx_q == `IDX_MEASURE_CTRL);

    // ----------------------------------------------------------------
    // software control registers
    // ----------------------------------------------------------------
    reg_byte_t en_a_q;
    reg_byte_t en_b_q;
    reg_byte_t edge_q;
    reg_byte_t ref_q;
    reg_byte_t ctrl_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            en_a_q <= `RST_BYTE;
            en_b_q <= `RST_BYTE;
            edge_q <= `RST_BYTE;
            ref_q  <= `RST_BYTE;
            ctrl_q <= `RST_BYTE;
        end else begin
            if (we_en_a) en_a_q <= wbyte & `MASK_STATUS_A;
            if (we_en_b) en_b_q <= wbyte & `MASK_STATUS_B;
            if (we_edge) edge_q <= wbyte & `MASK_STATUS_A;
            if (we_ref)  ref_q  <= wbyte & `MASK_REF;
            if (we_ctrl) ctrl_q <= wbyte & `MASK_CONTROL;
        end
    end

    // ----------------------------------------------------------------
    // live line status and edge detection
    // ----------------------------------------------------------------
    logic df_prev_q;
    logic los_prev_q;
    logic df_edge;
    logic los_edge;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            df_prev_q  <= 1'b0;
            los_prev_q <= 1'b0;
        end else begin
            df_prev_q  <= driver_fail_live;
            los_prev_q <= signal_loss_live;
        end
    end

    // edge select zero: rising only; one: either direction
    assign df_edge  = edge_q[`BIT_DRIVER_FAIL] ?
                      (driver_fail_live ^ df_prev_q) :
                      (driver_fail_live & ~df_prev_q);
    assign los_edge = edge_q[`BIT_SIGNAL_LOSS] ?
                      (signal_loss_live ^ los_prev_q) :
                      (signal_loss_live & ~los_prev_q);

    // ----------------------------------------------------------------
    // excessive zero counter and snapshot
    // ----------------------------------------------------------------
    logic [15:0] zero_cnt_q;
    logic [15:0] snap_q;
    logic        trig_prev_q;
    logic        cnt_wrap;
    logic        snap_take;

    assign cnt_wrap  = excess_zeros & (zero_cnt_q == `COUNT_FULL);
    assign snap_take = ctrl_q[`BIT_SNAP_TRIGGER] & ~trig_prev_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            zero_cnt_q  <= `RST_COUNT;
            snap_q      <= `RST_COUNT;
            trig_prev_q <= 1'b0;
        end else begin
            if (excess_zeros) zero_cnt_q <= zero_cnt_q + 16'h0001;
            if (snap_take) snap_q <= zero_cnt_q;
            trig_prev_q <= ctrl_q[`BIT_SNAP_TRIGGER];
        end
    end

    // ----------------------------------------------------------------
    // sticky event flags
    // ----------------------------------------------------------------
    reg_byte_t set_a;
    reg_byte_t set_b;
    reg_byte_t clr_a;
    reg_byte_t clr_b;
    reg_byte_t stat_a;
    reg_byte_t stat_b;

    assign set_a = {5'h00, df_edge, 1'b0, los_edge};
    assign set_b = {1'b0,
                    template_overflow,
                    tx_fifo_slip,
                    rx_fifo_slip,
                    1'b0,
                    excess_zeros,
                    bipolar_violation,
                    cnt_wrap};
    assign clr_a = {8{we_stat_a}} & wbyte;
    assign clr_b = {8{we_stat_b}} & wbyte;

    sticky_flags #(
        .WIDTH (8)
    ) u_flags_a (
        .hclk    (hclk),
        .hresetn (hresetn),
        .set     (set_a),
        .clr     (clr_a),
        .flags   (stat_a)
    );

    sticky_flags #(
        .WIDTH (8)
    ) u_flags_b (
        .hclk    (hclk),
        .hresetn (hresetn),
        .set     (set_b),
        .clr     (clr_b),
        .flags   (stat_b)
    );

    // ----------------------------------------------------------------
    // jitter fifo pointer distance
    // ----------------------------------------------------------------
    gap_t tx_gap;
    gap_t rx_gap;
    gap_t tx_value;
    gap_t rx_value;
    logic rd_tx_gap;
    logic rd_rx_gap;

    // pointers narrower than seven bits wrap at their own width
    assign tx_gap    = gap_t'(PTR_W'(tx_wr_ptr - tx_rd_ptr));
    assign rx_gap    = gap_t'(PTR_W'(rx_wr_ptr - rx_rd_ptr));
    assign rd_tx_gap = take_rd & (aidx == `IDX_TX_GAP);
    assign rd_rx_gap = take_rd & (aidx == `IDX_RX_GAP);

    pointer_gap_meter u_tx_gap (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .gap       (tx_gap),
        .peak_mode (ctrl_q[`BIT_TX_PEAK_MODE]),
        .clear     (we_tx_gap & (wbyte != 8'h00)),
        .read_ack  (rd_tx_gap),
        .value     (tx_value)
    );

    pointer_gap_meter u_rx_gap (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .gap       (rx_gap),
        .peak_mode (ctrl_q[`BIT_RX_PEAK_MODE]),
        .clear     (we_rx_gap & (wbyte != 8'h00)),
        .read_ack  (rd_rx_gap),
        .value     (rx_value)
    );

    // ----------------------------------------------------------------
    // interrupt summaries
    // ----------------------------------------------------------------
    logic      line_pending;
    reg_byte_t block_q;

    assign line_pending = |(stat_a & en_a_q) | |(stat_b & en_b_q);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            block_q <= `RST_BYTE;
        end else begin
            block_q <= block_pending;
        end
    end

    // ----------------------------------------------------------------
    // register read selection
    // ----------------------------------------------------------------
    reg_byte_t rbyte;

    always_comb begin
        if (aidx == `IDX_IRQ_ENABLE_A) begin
            rbyte = en_a_q;
        end else if (aidx == `IDX_IRQ_ENABLE_B) begin
            rbyte = en_b_q;
        end else if (aidx == `IDX_EDGE_SELECT) begin
            rbyte = edge_q;
        end else if (aidx == `IDX_LIVE_STATUS) begin
            rbyte = {5'h00, df_prev_q, 1'b0, los_prev_q};
        end else if (aidx == `IDX_TX_GAP) begin
            rbyte = {1'b0, tx_value};
        end else if (aidx == `IDX_RX_GAP) begin
            rbyte = {1'b0, rx_value};
        end else if (aidx == `IDX_STATUS_A) begin
            rbyte = stat_a;
        end else if (aidx == `IDX_STATUS_B) begin
            rbyte = stat_b;
        end else if (aidx == `IDX_COUNT_HIGH) begin
            rbyte = snap_q[15:8];
        end else if (aidx == `IDX_COUNT_LOW) begin
            rbyte = snap_q[7:0];
        end else if (aidx == `IDX_REF_CONTROL) begin
            rbyte = ref_q;
        end else if (aidx == `IDX_LINE_SUMMARY) begin
            rbyte = {7'h00, line_pending};
        end else if (aidx == `IDX_BLOCK_SUMMARY) begin
            rbyte = block_q;
        end else if (aidx == `IDX_MEASURE_CTRL) begin
            rbyte = ctrl_q;
        end else begin
            rbyte = `RST_BYTE;
        end
    end

    // ----------------------------------------------------------------
    // registered outputs
    // ----------------------------------------------------------------
    logic ref_level;

    // the reference is a sampled level, so it toggles at most at half hclk
    assign ref_level = !signal_loss_live      ? recovered_clk_level :
                       ref_q[`BIT_REF_HOLD]   ? 1'b1 :
                                                mclk_level;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata          <= 32'h0000_0000;
            hreadyout       <= 1'b1;
            hresp           <= 1'b0;
            ref_clock_out_a <= 1'b0;
            ref_clock_out_b <= 1'b0;
            irq             <= 1'b0;
        end else begin
            if (take_rd) hrdata <= {24'h00_0000, rbyte};
            hreadyout       <= 1'b1;
            hresp           <= 1'b0;
            ref_clock_out_a <= ref_level;
            ref_clock_out_b <= ref_level;
            irq             <= line_pending;
        end
    end
endmodule
`default_nettype wire

/* hw/line_event_defs.svh */
// register indices, field positions and reset values of the line event block
`ifndef LINE_EVENT_DEFS_SVH
`define LINE_EVENT_DEFS_SVH

// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define IDX_IRQ_ENABLE_A    10'h033
`define IDX_IRQ_ENABLE_B    10'h034
`define IDX_EDGE_SELECT     10'h035
`define IDX_LIVE_STATUS     10'h036
`define IDX_TX_GAP          10'h038
`define IDX_RX_GAP          10'h039
`define IDX_STATUS_A        10'h03a
`define IDX_STATUS_B        10'h03b
`define IDX_COUNT_HIGH      10'h03c
`define IDX_COUNT_LOW       10'h03d
`define IDX_REF_CONTROL     10'h03e
`define IDX_LINE_SUMMARY    10'h03f
`define IDX_BLOCK_SUMMARY   10'h040
`define IDX_MEASURE_CTRL    10'h048

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define BIT_DRIVER_FAIL     2
`define BIT_SIGNAL_LOSS     0
`define BIT_TEMPLATE_OVF    6
`define BIT_TX_SLIP         5
`define BIT_RX_SLIP         4
`define BIT_ZERO_RUN        2
`define BIT_CODE_VIOL       1
`define BIT_COUNT_WRAP      0
`define BIT_TX_PEAK_MODE    0
`define BIT_RX_PEAK_MODE    1
`define BIT_SNAP_TRIGGER    2
`define BIT_REF_HOLD        0
`define BIT_LINE_PENDING    0

// ----------------------------------------------------------------
// reset values and used-bit masks
// ----------------------------------------------------------------
`define RST_BYTE            8'h00
`define RST_COUNT           16'h0000
`define MASK_STATUS_A       8'h05
`define MASK_STATUS_B       8'h77
`define MASK_CONTROL        8'h07
`define MASK_REF            8'h01
`define COUNT_FULL          16'hffff

`endif

/* hw/line_event_pkg.sv */
// shared types of the line event block
`default_nettype none
package line_event_pkg;
    typedef logic [7:0] reg_byte_t;
    typedef logic [9:0] reg_idx_t;
    typedef logic [6:0] gap_t;
endpackage
`default_nettype wire

/* hw/sticky_flags.sv */
// bank of sticky event flags, set by hardware, cleared by writing one
`default_nettype none
module sticky_flags #(
    parameter int WIDTH = 8
) (
    input  wire logic             hclk,
    input  wire logic             hresetn,
    input  wire logic [WIDTH-1:0] set,
    input  wire logic [WIDTH-1:0] clr,
    output logic      [WIDTH-1:0] flags
);
    initial begin
        if (WIDTH < 1) $error("sticky_flags: WIDTH must be at least 1");
    end

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_flag
            logic flag_q;
            logic flag_d;
            // set wins over a clear in the same cycle, so no event is lost
            assign flag_d = set[i] | (flag_q & ~clr[i]);
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    flag_q <= 1'b0;
                end else begin
                    flag_q <= flag_d;
                end
            end
            assign flags[i] = flag_q;
        end
    endgenerate
endmodule
`default_nettype wire

/* hw/pointer_gap_meter.sv */
// jitter fifo pointer distance, live or peak-to-peak since last read
`default_nettype none
module pointer_gap_meter
    import line_event_pkg::*;
(
    input  wire logic hclk,
    input  wire logic hresetn,
    input  wire gap_t gap,
    input  wire logic peak_mode,
    input  wire logic clear,
    input  wire logic read_ack,
    output gap_t      value
);
    gap_t min_q;
    gap_t max_q;
    gap_t value_q;
    gap_t min_d;
    gap_t max_d;
    gap_t value_d;
    logic restart;

    // a read or a clearing write opens a new peak window
    assign restart = clear | read_ack;
    assign min_d   = (restart || gap < min_q) ? gap : min_q;
    assign max_d   = (restart || gap > max_q) ? gap : max_q;
    assign value_d = clear     ? 7'h00 :
                     peak_mode ? gap_t'(max_d - min_d) :
                                 gap;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            min_q   <= 7'h00;
            max_q   <= 7'h00;
            value_q <= 7'h00;
        end else begin
            min_q   <= min_d;
            max_q   <= max_d;
            value_q <= value_d;
        end
    end

    assign value = value_q;
endmodule
`default_nettype wire

/* tb/line_event_status_sva.sv */
// checker of the line event block, bound to its top module
`default_nettype none
`include "line_event_defs.svh"
module line_event_status_chk #(
    parameter int ADDR_W = 12
) (
    input wire logic              hclk,
    input wire logic              hresetn,
    input wire logic              hsel,
    input wire logic [ADDR_W-1:0] haddr,
    input wire logic [1:0]        htrans,
    input wire logic              hwrite,
    input wire logic              hready,
    input wire logic [31:0]       hrdata,
    input wire logic              driver_fail_live,
    input wire logic              signal_loss_live,
    input wire logic              template_overflow,
    input wire logic              excess_zeros,
    input wire logic              bipolar_violation,
    input wire logic              mclk_level,
    input wire logic              recovered_clk_level,
    input wire logic              ref_clock_out_a,
    input wire logic              ref_clock_out_b
);
    wire logic [9:0] idx;
    wire logic       rd_take;
    wire logic       rd_a;
    wire logic       rd_b;
    assign idx     = haddr[11:2];
    assign rd_take = hsel && htrans[1] && hready && !hwrite;
    assign rd_a    = rd_take && idx == `IDX_STATUS_A;
    assign rd_b    = rd_take && idx == `IDX_STATUS_B;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    property p_gap_width;
        rd_take && (idx == `IDX_TX_GAP || idx == `IDX_RX_GAP) |=> hrdata[31:7] == 25'h0;
    endproperty
    a_gap_width: assert property (p_gap_width)
        else $error("jitter field wider than seven bits");
    property p_template;
        template_overflow ##1 rd_b |=> hrdata[`BIT_TEMPLATE_OVF];
    endproperty
    a_template: assert property (p_template)
        else $error("template overflow flag not latched");
    property p_zero_run;
        excess_zeros ##1 rd_b |=> hrdata[`BIT_ZERO_RUN];
    endproperty
    a_zero_run: assert property (p_zero_run)
        else $error("zero run flag not latched");
    property p_code_viol;
        bipolar_violation ##1 rd_b |=> hrdata[`BIT_CODE_VIOL];
    endproperty
    a_code_viol: assert property (p_code_viol)
        else $error("code violation flag not latched");
    property p_driver_rise;
        $rose(driver_fail_live) ##1 rd_a |=> hrdata[`BIT_DRIVER_FAIL];
    endproperty
    a_driver_rise: assert property (p_driver_rise)
        else $error("driver fail rise not latched");
    property p_ref_pair;
        ref_clock_out_a == ref_clock_out_b;
    endproperty
    a_ref_pair: assert property (p_ref_pair)
        else $error("reference outputs differ");
    // three quiet cycles so a registered copy of the loss level cannot confuse it
    property p_ref_live;
        $past(hresetn) && !signal_loss_live && !$past(signal_loss_live)
            && !$past(signal_loss_live, 2) |-> ref_clock_out_a == $past(recovered_clk_level);
    endproperty
    a_ref_live: assert property (p_ref_live)
        else $error("reference output not following line clock");
    property p_ref_loss;
        $past(hresetn) && signal_loss_live && $past(signal_loss_live)
            && $past(signal_loss_live, 2) |-> ref_clock_out_a || !$past(mclk_level);
    endproperty
    a_ref_loss: assert property (p_ref_loss)
        else $error("reference output low while master clock high");
endmodule

bind line_event_status line_event_status_chk #(.ADDR_W(ADDR_W)) i_chk (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready, .hrdata,
    .driver_fail_live, .signal_loss_live, .template_overflow, .excess_zeros,
    .bipolar_violation, .mclk_level, .recovered_clk_level,
    .ref_clock_out_a, .ref_clock_out_b
);
`default_nettype wire

/* tb/tb_line_event_status.sv */
// self-checking bench of the line event block over its register bus
`default_nettype none
`include "line_event_defs.svh"
module tb_line_event_status import line_event_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
    logic        ref_clock_out_a, ref_clock_out_b, mclk_level, recovered_clk_level;
    logic        driver_fail_live, signal_loss_live, template_overflow, tx_fifo_slip;
    logic        rx_fifo_slip, excess_zeros, bipolar_violation;
    logic [11:0] haddr;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] hwdata, hrdata;
    logic [6:0]  tx_wr_ptr, tx_rd_ptr, rx_wr_ptr, rx_rd_ptr;
    logic [7:0]  block_pending;
    wire logic   hready;
    reg_byte_t   got;
    int          mismatches, samples_checked, cycles;
    reg_idx_t    idxs[10] = '{`IDX_TX_GAP, `IDX_RX_GAP, `IDX_STATUS_A, `IDX_STATUS_B,
        `IDX_COUNT_HIGH, `IDX_COUNT_LOW, `IDX_REF_CONTROL, `IDX_LINE_SUMMARY,
        `IDX_BLOCK_SUMMARY, 10'h000};

    assign hready = hreadyout;
    line_event_status i_dut (
        .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
        .hreadyout, .hrdata, .hresp, .driver_fail_live, .signal_loss_live,
        .template_overflow, .tx_fifo_slip, .rx_fifo_slip, .excess_zeros,
        .bipolar_violation, .tx_wr_ptr, .tx_rd_ptr, .rx_wr_ptr, .rx_rd_ptr, .mclk_level,
        .recovered_clk_level, .block_pending, .ref_clock_out_a, .ref_clock_out_b, .irq
    );

    initial begin
        hclk = 1'h0;
        forever #2 hclk = ~hclk;
    end

    // --------------------------------------------------------------
    // shared tasks
    // --------------------------------------------------------------
    task automatic report_and_stop;
        if (mismatches == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input reg_byte_t seen, input reg_byte_t exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // the master waits on hready, it assumes no wait-state count
    task automatic xfer(input reg_idx_t idx, input logic wr, input reg_byte_t wd,
                        output reg_byte_t rd);
        hsel   <= 1'h1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr  <= {idx, 2'h0};
        do @(posedge hclk); while (hready !== 1'h1);
        hsel   <= 1'h0;
        htrans <= 2'h0;
        hwdata <= 32'(wd);
        do @(posedge hclk); while (hready !== 1'h1);
        rd = hrdata[7:0];
    endtask

    task automatic wreg(input reg_idx_t idx, input reg_byte_t wd);
        reg_byte_t unused;
        xfer(idx, 1'h1, wd, unused);
    endtask

    task automatic rchk(input string what, input reg_idx_t idx, input reg_byte_t exp);
        reg_byte_t seen;
        xfer(idx, 1'h0, 8'h00, seen);
        chk(what, seen, exp);
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge hclk);
    endtask

    task automatic chk_irq(input logic exp);
        tick(2);
        #1;
        chk("irq", {7'h00, irq}, {7'h00, exp});
        @(posedge hclk);
    endtask

    // the trigger must fall before it can rise again
    task automatic snap(input logic [15:0] exp);
        wreg(`IDX_MEASURE_CTRL, 8'h00);
        wreg(`IDX_MEASURE_CTRL, 8'h04);
        tick(2);
        rchk("count high byte", `IDX_COUNT_HIGH, exp[15:8]);
        rchk("count low byte", `IDX_COUNT_LOW, exp[7:0]);
    endtask

    always @(posedge hclk) begin
        cycles++;
        mclk_level          <= cycles[0];
        recovered_clk_level <= cycles[1];
        if (cycles == 80000) begin
            mismatches++;
            report_and_stop();
        end
    end

    // --------------------------------------------------------------
    // main sequence
    // --------------------------------------------------------------
    initial begin
        {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
        {driver_fail_live, signal_loss_live, template_overflow, tx_fifo_slip} = 4'h0;
        {rx_fifo_slip, excess_zeros, bipolar_violation} = 3'h0;
        {tx_wr_ptr, tx_rd_ptr, rx_wr_ptr, rx_rd_ptr, block_pending} = '0;
        hsize = 3'h2;
        tick(8);
        hresetn <= 1'h1;
        tick(1);
        foreach (idxs[i]) rchk("reset value", idxs[i], 8'h00);
        chk("bus response", {6'h00, hreadyout, hresp}, 8'h02);
        {template_overflow, tx_fifo_slip, rx_fifo_slip, excess_zeros, bipolar_violation} <= 5'h1f;
        tick(1);
        {template_overflow, tx_fifo_slip, rx_fifo_slip, excess_zeros, bipolar_violation} <= 5'h00;
        rchk("event flags", `IDX_STATUS_B, 8'h76);
        wreg(`IDX_STATUS_B, 8'h40);
        rchk("partial clear", `IDX_STATUS_B, 8'h36);
        wreg(`IDX_STATUS_B, 8'h36);
        rchk("full clear", `IDX_STATUS_B, 8'h00);
        wreg(`IDX_IRQ_ENABLE_B, 8'h02);
        bipolar_violation <= 1'h1;
        tick(1);
        bipolar_violation <= 1'h0;
        chk_irq(1'h1);
        rchk("line summary", `IDX_LINE_SUMMARY, 8'h01);
        wreg(`IDX_IRQ_ENABLE_B, 8'h00);
        chk_irq(1'h0);
        wreg(`IDX_IRQ_ENABLE_B, 8'h02);
        chk_irq(1'h1);
        wreg(`IDX_STATUS_B, 8'h02);
        chk_irq(1'h0);
        wreg(`IDX_IRQ_ENABLE_B, 8'h00);
        block_pending <= 8'ha5;
        tick(2);
        rchk("module indication", `IDX_BLOCK_SUMMARY, 8'ha5);
        block_pending <= 8'h5a;
        tick(2);
        rchk("module indication", `IDX_BLOCK_SUMMARY, 8'h5a);
        for (int sel = 0; sel < 2; sel++) begin
            wreg(`IDX_EDGE_SELECT, sel ? 8'h05 : 8'h00);
            {driver_fail_live, signal_loss_live} <= 2'h3;
            tick(1);
            rchk("rise flags", `IDX_STATUS_A, 8'h05);
            wreg(`IDX_STATUS_A, 8'h05);
            {driver_fail_live, signal_loss_live} <= 2'h0;
            tick(1);
            rchk("fall flags", `IDX_STATUS_A, sel ? 8'h05 : 8'h00);
            wreg(`IDX_STATUS_A, 8'h05);
        end
        excess_zeros <= 1'h1;
        tick(300);
        excess_zeros <= 1'h0;
        snap(16'h012d);
        excess_zeros <= 1'h1;
        tick(10);
        excess_zeros <= 1'h0;
        wreg(`IDX_MEASURE_CTRL, 8'h04);
        tick(2);
        rchk("count held", `IDX_COUNT_LOW, 8'h2d);
        snap(16'h0137);
        wreg(`IDX_STATUS_B, 8'hff);
        excess_zeros <= 1'h1;
        tick(65536 - 311 + 5);
        excess_zeros <= 1'h0;
        snap(16'h0005);
        rchk("wrap flag", `IDX_STATUS_B, 8'h05);
        {tx_wr_ptr, tx_rd_ptr, rx_wr_ptr, rx_rd_ptr} <= {7'h02, 7'h78, 7'h32, 7'h14};
        tick(3);
        rchk("tx gap live", `IDX_TX_GAP, 8'h0a);
        rchk("rx gap live", `IDX_RX_GAP, 8'h1e);
        wreg(`IDX_RX_GAP, 8'h01);
        rchk("rx gap cleared", `IDX_RX_GAP, 8'h00);
        rchk("rx gap resumed", `IDX_RX_GAP, 8'h1e);
        {tx_wr_ptr, tx_rd_ptr} <= {7'h05, 7'h00};
        tick(3);
        wreg(`IDX_MEASURE_CTRL, 8'h03);
        xfer(`IDX_TX_GAP, 1'h0, 8'h00, got);
        tick(3);
        tx_wr_ptr <= 7'h14;
        tick(3);
        tx_wr_ptr <= 7'h0c;
        tick(3);
        rchk("tx gap peak", `IDX_TX_GAP, 8'h0f);
        // a read opens a new window; the swing is 0x2c down to 0x1e
        xfer(`IDX_RX_GAP, 1'h0, 8'h00, got);
        rx_wr_ptr <= 7'h40;
        tick(3);
        rx_wr_ptr <= 7'h32;
        tick(3);
        rchk("rx gap peak", `IDX_RX_GAP, 8'h0e);
        wreg(`IDX_REF_CONTROL, 8'h01);
        rchk("ref control", `IDX_REF_CONTROL, 8'h01);
        signal_loss_live <= 1'h1;
        tick(3);
        #1;
        chk("ref held high", {6'h00, ref_clock_out_a, ref_clock_out_b}, 8'h03);
        @(posedge hclk);
        wreg(`IDX_REF_CONTROL, 8'h00);
        tick(3);
        #1;
        chk("ref master clock", {7'h00, ref_clock_out_a}, {7'h00, ~mclk_level});
        report_and_stop();
    end
endmodule
`default_nettype wire
